// ===== testbench/pio_switch_command_engine_bench.sv
/*
  Self-checking bench of the switch engine, driven by the master model.
  Assumes open-drain pins with pull-ups and a powered auxiliary supply.
*/
`timescale 1ns/100ps
module pio_switch_command_engine_bench;
  logic mclk = 1'b0;
  logic rst, fast, cfg_wr, act_clear, aux, rz_drv, rz_oe, rz_out, tx_bit;
  logic bus_reset, ctl_start, slot_begin, slot_end, line_level, resp;
  logic [15:0] cfg_addr;
  logic [7:0] cfg_data, ext, pin_oe, pin_out, mask_m, pol_m, latch_m, act_m;
  logic [3:0] ctl_m;
  int seed = 35, mismatches = 0, n_compared = 0, cycles = 0, strobes = 0;
  wire logic [7:0] pin_in = ext & ~pin_oe;
  wire logic rz_in = rz_drv & ~rz_oe;

  initial forever #50 mclk = ~mclk;

  psc_engine u_psc_engine
  (
    .mclk(mclk), .rst(rst), .ce(1'b1), .bus_reset(bus_reset),
    .ctl_start(ctl_start), .fast_speed_flag(fast), .slot_begin(slot_begin),
    .slot_end(slot_end), .line_level(line_level), .cfg_wr(cfg_wr),
    .cfg_addr(cfg_addr), .cfg_data(cfg_data), .act_clear(act_clear),
    .channel_pin_in(pin_in), .channel_pin_out(pin_out),
    .channel_pin_oe(pin_oe), .reset_strobe_pin_in(rz_in),
    .reset_strobe_pin_out(rz_out), .reset_strobe_pin_oe(rz_oe),
    .aux_supply_pin(aux), .tx_bit(tx_bit), .search_response(resp)
  );

  psc_master u_psc_master
  (
    .mclk(mclk), .fast(fast), .tx_bit(tx_bit), .slot_begin(slot_begin),
    .slot_end(slot_end), .line_level(line_level), .ctl_start(ctl_start),
    .bus_reset(bus_reset)
  );

  always @(posedge rz_oe) strobes++;

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      mismatches++;
      final_report();
    end
  end

  task automatic check(string n, logic [7:0] seen, logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", n, exp, seen);
    end
  endtask

  function automatic logic [15:0] crc_add(logic [15:0] c, logic [7:0] b);
    for (int i = 0; i < 8; i++)
      c = (c[0] ^ b[i]) ? (c >> 1) ^ 16'ha001 : c >> 1;
    return c;
  endfunction

  function automatic logic [7:0] reg_val(logic [15:0] a);
    case (a)
      16'h0088: return ext & latch_m;
      16'h0089: return latch_m;
      16'h008a: return act_m;
      16'h008b: return mask_m;
      16'h008c: return pol_m;
      16'h008d: return {aux, 3'h0, ctl_m};
      default: return 8'hff;
    endcase
  endfunction

  function automatic logic exp_resp();
    logic [7:0] hit;
    hit = ~((ctl_m[0] ? act_m : ext & latch_m) ^ pol_m) & mask_m;
    return ctl_m[3] | (ctl_m[1] ? hit == mask_m : |hit);
  endfunction

  task automatic cfg(logic [15:0] a, logic [7:0] d);
    @(negedge mclk);
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_data = d;
    @(negedge mclk);
    cfg_wr = 1'b0;
    case (a)
      16'h008b: mask_m = d;
      16'h008c: pol_m = d;
      default: ctl_m = {ctl_m[3] & d[3], d[2:0]};
    endcase
  endtask

  task automatic set_ext(logic [7:0] v);
    @(negedge mclk);
    act_m = act_m | ((v ^ ext) & latch_m);
    ext = v;
  endtask

  task automatic read_regs(logic [15:0] a);
    logic [7:0] r;
    logic [15:0] c;
    c = crc_add(crc_add(crc_add(16'h0000, 8'hf0), a[7:0]), a[15:8]);
    u_psc_master.start(8'hf0);
    u_psc_master.xfer(a[7:0], r);
    u_psc_master.xfer(a[15:8], r);
    for (logic [15:0] x = a; x <= 16'h008f; x++)
    begin
      u_psc_master.xfer(8'hff, r);
      check("register", r, reg_val(x));
      c = crc_add(c, reg_val(x));
    end
    u_psc_master.xfer(8'hff, r);
    check("crc low", r, ~c[7:0]);
    u_psc_master.xfer(8'hff, r);
    check("crc high", r, ~c[15:8]);
    u_psc_master.xfer(8'hff, r);
    check("fill", r, 8'hff);
    u_psc_master.reset_bus();
  endtask

  task automatic write_pair(logic [7:0] d, logic [7:0] inv);
    logic [7:0] r;
    u_psc_master.xfer(d, r);
    u_psc_master.xfer(inv, r);
    u_psc_master.xfer(8'hff, r);
    if (inv === ~d)
    begin
      act_m = act_m | (ext & (latch_m ^ d));
      latch_m = d;
      check("confirm", r, 8'haa);
      u_psc_master.xfer(8'hff, r);
      check("status", r, ext & d);
    end
    else
      check("refused", r, 8'hff);
    check("enables", pin_oe, ~latch_m);
  endtask

  initial
  begin
    logic [7:0] d, r;
    logic [15:0] c;
    rst = 1'b1;
    fast = 1'b1;
    {cfg_wr, act_clear, aux, rz_drv} = 4'h3;
    cfg_addr = 16'h0000;
    cfg_data = 8'h00;
    ext = 8'hff;
    {mask_m, pol_m, act_m, latch_m} = 32'h000000ff;
    ctl_m = 4'h8;
    repeat (20) @(negedge mclk);
    rst = 1'b0;
    repeat (5) @(negedge mclk);
    check("power-up search", 8'(resp), 8'h01);
    read_regs(16'h0088);
    cfg(16'h008d, 8'h00);
    @(negedge mclk) act_clear = 1'b1;
    @(negedge mclk) act_clear = 1'b0;
    for (int i = 0; i < 12; i++)
    begin
      set_ext(8'($random(seed)));
      cfg(16'h008b, i < 2 ? 8'h04 : 8'($random(seed)) | 8'h01);
      cfg(16'h008c, 8'($random(seed)));
      cfg(16'h008d, 8'(i % 4));
      repeat (8) @(negedge mclk);
      check("search", 8'(resp), 8'(exp_resp()));
    end
    fast = 1'b0;
    read_regs(16'h0086);
    fast = 1'b1;
    read_regs(16'h0090);
    cfg(16'h008d, 8'h04);
    strobes = 0;
    u_psc_master.start(8'h5a);
    for (int i = 0; i < 5; i++)
    begin
      d = i == 0 ? 8'h7f : i == 1 ? 8'h80 : 8'($random(seed));
      write_pair(d, ~d);
    end
    check("write strobes", 8'(strobes), 8'h05);
    write_pair(8'h3c, 8'hc2);
    u_psc_master.reset_bus();
    strobes = 0;
    c = crc_add(16'h0000, 8'hf5);
    u_psc_master.start(8'hf5);
    for (int i = 0; i < 32; i++)
    begin
      u_psc_master.xfer(8'hff, r);
      check("stream", r, ext & latch_m);
      c = crc_add(c, ext & latch_m);
    end
    u_psc_master.xfer(8'hff, r);
    check("stream crc low", r, ~c[7:0]);
    u_psc_master.xfer(8'hff, r);
    check("stream crc high", r, ~c[15:8]);
    u_psc_master.xfer(8'hff, r);
    check("stream next", r, ext & latch_m);
    check("stream strobes", 8'(strobes), 8'h22);
    u_psc_master.reset_bus();
    cfg(16'h008d, 8'h00);
    rz_drv = 1'b0;
    repeat (10) @(negedge mclk);
    check("forced off", pin_oe, 8'h00);
    {latch_m, act_m} = 16'hff00;
    read_regs(16'h0088);
    final_report();
  end
endmodule

// ===== testbench/psc_engine_properties.sv
/*
  Port checker of the switch engine, bound into every psc_engine.
  Assumes one clock, mclk, and the active-high reset rst.
*/
`timescale 1ns/100ps
module psc_engine_properties
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic bus_reset,
  input wire logic slot_begin,
  input wire logic slot_end,
  input wire logic cfg_wr,
  input wire logic [15:0] cfg_addr,
  input wire logic [7:0] cfg_data,
  input wire logic reset_strobe_pin_in,
  input wire logic [7:0] channel_pin_out,
  input wire logic [7:0] channel_pin_oe,
  input wire logic reset_strobe_pin_out,
  input wire logic reset_strobe_pin_oe,
  input wire logic tx_bit,
  input wire logic search_response
);
  logic role_r;
  logic por_r;
  logic slot_r;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // Mirrors the strobe role, the power-up flag and whether a slot is open.
  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      role_r <= 1'b0;
      por_r <= 1'b1;
      slot_r <= 1'b0;
    end
    else
    begin
      if (cfg_wr && cfg_addr == 16'h008d)
      begin
        role_r <= cfg_data[2];
        por_r <= por_r & cfg_data[3];
      end
      slot_r <= slot_begin | (slot_r & ~slot_end);
    end

  a_tx_slot_edge: assert property (
    $changed(tx_bit) |-> $past(slot_end) || $past(slot_end, 2) ||
      $past(bus_reset) || $past(bus_reset, 2))
    else $error("tx_bit moved away from a slot end");
  a_reset_idle: assert property (bus_reset |-> ##2 tx_bit)
    else $error("tx_bit low after a bus reset");
  a_open_drain: assert property (
    channel_pin_out == 8'h00 && !reset_strobe_pin_out)
    else $error("a pin drives high");
  a_reset_pin_off: assert property (
    (!role_r && !reset_strobe_pin_in) [*5] |-> channel_pin_oe == 8'h00)
    else $error("outputs on while reset input low");
  a_strobe_role: assert property (
    !role_r && !$past(role_r) |-> !reset_strobe_pin_oe)
    else $error("strobe driven in reset input role");
  a_strobe_rise: assert property (
    $rose(reset_strobe_pin_oe) |-> $past(slot_end) || $past(slot_end, 2))
    else $error("strobe began away from a slot end");
  a_strobe_fall: assert property (
    $fell(reset_strobe_pin_oe) |-> $past(slot_r) || $past(bus_reset) ||
      $past(bus_reset, 2))
    else $error("strobe ended outside a slot");
  a_strobe_width: assert property (
    $rose(reset_strobe_pin_oe) |-> ##[1:600] !reset_strobe_pin_oe)
    else $error("strobe too long");
  a_por_search: assert property (
    !$past(rst) && $past(por_r) |-> search_response)
    else $error("search response low with power-up flag set");
  a_latch_write: assert property (
    role_r && $past(role_r) && $changed(channel_pin_oe) |->
      $past(slot_r) || $past(slot_end) || $past(slot_end, 2))
    else $error("outputs moved outside a write slot");
endmodule

bind psc_engine psc_engine_properties u_psc_engine_properties
(
  .mclk(mclk), .rst(rst), .bus_reset(bus_reset), .slot_begin(slot_begin),
  .slot_end(slot_end), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
  .cfg_data(cfg_data), .reset_strobe_pin_in(reset_strobe_pin_in),
  .channel_pin_out(channel_pin_out), .channel_pin_oe(channel_pin_oe),
  .reset_strobe_pin_out(reset_strobe_pin_out),
  .reset_strobe_pin_oe(reset_strobe_pin_oe), .tx_bit(tx_bit),
  .search_response(search_response)
);

// ===== testbench/psc_master.sv
/*
  Bus master model: control starts, bit slots, bytes and bus resets.
  Assumes the engine takes tx_bit at slot_begin; outputs move at the
  falling edge of mclk and the idle line is pulled high.
*/
`timescale 1ns/100ps
module psc_master
(
  input wire logic mclk,
  input wire logic fast,
  input wire logic tx_bit,
  output logic slot_begin,
  output logic slot_end,
  output logic line_level,
  output logic ctl_start,
  output logic bus_reset
);
  initial
  begin
    {slot_begin, slot_end, ctl_start, bus_reset} = 4'h0;
    line_level = 1'b1;
  end

  // A written 1 or a read releases the line, so the engine's bit wins.
  task automatic slot(input logic wb, output logic rb);
    @(negedge mclk);
    slot_begin = 1'b1;
    line_level = 1'b0;
    @(negedge mclk);
    slot_begin = 1'b0;
    rb = wb & tx_bit;
    line_level = rb;
    repeat (fast ? 22 : 152) @(negedge mclk);
    slot_end = 1'b1;
    line_level = 1'b1;
    @(negedge mclk);
    slot_end = 1'b0;
  endtask

  task automatic xfer(input logic [7:0] w, output logic [7:0] r);
    for (int i = 0; i < 8; i++)
      slot(w[i], r[i]);
  endtask

  task automatic start(input logic [7:0] cmd);
    logic [7:0] r;
    @(negedge mclk);
    ctl_start = 1'b1;
    @(negedge mclk);
    ctl_start = 1'b0;
    xfer(cmd, r);
  endtask

  task automatic reset_bus();
    @(negedge mclk);
    bus_reset = 1'b1;
    @(negedge mclk);
    bus_reset = 1'b0;
    repeat (4) @(negedge mclk);
  endtask
endmodule

// ===== verilog/psc_crc16.sv
/*
  Sixteen-bit checksum generator, shifted one bit at a time, least
  significant bit first, reflected polynomial.
  Assumes clear and shift never come in the same cycle as a hazard: clear
  wins.
*/
`timescale 1ns/100ps
`include "psc_defs.svh"

module psc_crc16
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic clear,
  input wire logic shift,
  input wire logic din,
  output logic [15:0] crc
);
  import psc_pkg::*;

  psc_crc_t q_r;
  psc_crc_t q_nxt;

  always_comb
  begin
    q_nxt = q_r;
    if (clear)
    begin
      q_nxt.crc = 16'h0000;
    end
    else if (shift)
    begin
      q_nxt.crc = {1'b0, q_r.crc[15:1]} ^
                  ((q_r.crc[0] ^ din) ? `PSC_CRC_POLY : 16'h0000);
    end
    if (!ce)
    begin
      q_nxt = q_r;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      q_r <= '0;
    end
    else
    begin
      q_r <= q_nxt;
    end
  end

  assign crc = q_r.crc;
endmodule

// ===== verilog/psc_defs.svh
/*
  Constants of the switch command engine: register page addresses, command
  codes, control bit positions, reset values and slot timing counts.
  Assumes a 10 MHz engine clock.
*/
`ifndef PSC_DEFS_SVH
`define PSC_DEFS_SVH

// ---------------------------------------------------------------------------
// Register page
// ---------------------------------------------------------------------------
`define PSC_ADDR_PRESAMPLE 16'h0087
`define PSC_ADDR_PIN 16'h0088
`define PSC_ADDR_OUTL 16'h0089
`define PSC_ADDR_ACT 16'h008a
`define PSC_ADDR_MASK 16'h008b
`define PSC_ADDR_POL 16'h008c
`define PSC_ADDR_CTL 16'h008d
`define PSC_ADDR_LAST 16'h008f
`define PSC_LOW_PIN 8'h88

// ---------------------------------------------------------------------------
// Control bit positions and reset values
// ---------------------------------------------------------------------------
`define PSC_CTL_SRC_BIT 0
`define PSC_CTL_COMB_BIT 1
`define PSC_CTL_ROLE_BIT 2
`define PSC_CTL_POR_BIT 3
`define PSC_CTL_AUX_BIT 7
`define PSC_MASK_RESET 8'h00
`define PSC_POL_RESET 8'h00
`define PSC_ACT_RESET 8'h00
`define PSC_OUTL_RESET 8'hff
`define PSC_PIN_RESET 8'hff

// ---------------------------------------------------------------------------
// Commands and fixed data
// ---------------------------------------------------------------------------
`define PSC_CMD_READ_REGS 8'hf0
`define PSC_CMD_STREAM 8'hf5
`define PSC_CMD_WRITE 8'h5a
`define PSC_CONFIRM 8'haa
`define PSC_FILL 8'hff
`define PSC_STREAM_BYTES 32
`define PSC_CRC_POLY 16'ha001

// ---------------------------------------------------------------------------
// Timing
// ---------------------------------------------------------------------------
`define PSC_CLK_NS 100
`define PSC_SAMPLE_STD_NS 15000
`define PSC_SAMPLE_OD_NS 2000
`define PSC_SAMPLE_STD_CYC \
  ((`PSC_SAMPLE_STD_NS + `PSC_CLK_NS - 1) / `PSC_CLK_NS)
`define PSC_SAMPLE_OD_CYC \
  ((`PSC_SAMPLE_OD_NS + `PSC_CLK_NS - 1) / `PSC_CLK_NS)

`endif

// ===== verilog/psc_engine.sv
/*
  Control-function engine of an eight channel open-drain switch: register
  page read, streaming channel read, channel write, search qualification.
  Assumes a link layer on mclk that marks slot starts and ends, reports the
  line level and latches tx_bit at each slot start.
*/
// Overview of operation
// - Control bit 0 picks pins or activity latches as search source.
// - Control bit 1 picks OR or AND combining of selected channels.
// - Control bit 2 makes the reset/strobe pin reset input or strobe.
// - Control bit 3 set by power-up, software clears; forces search response.
// - Control bit 7 reads the auxiliary supply pin state.
// - Compare source with polarity per selected channel; combine bit picks.
// - OR needs one selected match; AND needs all selected to match.
// - Standard speed unless fast flag; slot timing follows speed.
// - Register read: code, two address bytes, data up to page end.
// - Past page end send inverted checksum of command, address, data.
// - After that checksum answer all reads with 1 until bus reset.
// - Pin snapshot taken one bit slot before address 0x88 is read.
// - Streaming read samples pins at each previous byte's last bit.
// - Every 32 pin bytes insert inverted checksum; next sample at its end.
// - In strobe role, stream strobes low over each pin byte's two LSBs.
// - Sample at fixed delay into slot; no strobe at write sampling.
// - Streaming read and write loop until a bus reset pulse.
// - Channel write alone updates the output latch; 1 means off.
// - Latch updates only when the second byte is the exact inverse.
// - Change at sample delay if last bit is 1, else at slot end.
// - After an update send confirmation byte 0xaa.
// - In strobe role strobe low over confirmation byte's two LSBs.
// - Sample pins at confirmation's last bit, send them, accept next pair.
// - Reset input held low forces outputs off, latch reads all ones.
// - Activity latch sets on any pin change, external or written.
`timescale 1ns/100ps
`include "psc_defs.svh"

module psc_engine
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  input wire logic bus_reset,
  input wire logic ctl_start,
  input wire logic fast_speed_flag,
  input wire logic slot_begin,
  input wire logic slot_end,
  input wire logic line_level,
  input wire logic cfg_wr,
  input wire logic [15:0] cfg_addr,
  input wire logic [7:0] cfg_data,
  input wire logic act_clear,
  input wire logic [7:0] channel_pin_in,
  output logic [7:0] channel_pin_out,
  output logic [7:0] channel_pin_oe,
  input wire logic reset_strobe_pin_in,
  output logic reset_strobe_pin_out,
  output logic reset_strobe_pin_oe,
  input wire logic aux_supply_pin,
  output logic tx_bit,
  output logic search_response
);
  import psc_pkg::*;

  localparam psc_eng_t RESET_Q = '{
    st: ST_IDLE,
    txsr: 16'hffff,
    pin_s1: `PSC_PIN_RESET,
    pin_s2: `PSC_PIN_RESET,
    pin_prev: `PSC_PIN_RESET,
    out_latch: `PSC_OUTL_RESET,
    act: `PSC_ACT_RESET,
    mask: `PSC_MASK_RESET,
    pol: `PSC_POL_RESET,
    ctl_por: 1'b1,
    tx_bit: 1'b1,
    default: '0
  };
  localparam logic [7:0] STD_M1 = 8'(`PSC_SAMPLE_STD_CYC - 1);
  localparam logic [7:0] OD_M1 = 8'(`PSC_SAMPLE_OD_CYC - 1);
  localparam logic [4:0] LAST_BYTE = 5'(`PSC_STREAM_BYTES - 1);

  psc_eng_t q_r;
  psc_eng_t q_nxt;
  logic [15:0] crc;
  logic crc_clear;
  logic crc_shift;
  logic crc_din;
  logic [7:0] cyc_m1;
  logic samp;
  logic rz_reset;
  logic [7:0] full;
  logic [7:0] src;
  logic [7:0] hit;
  logic [15:0] next_addr;

  // -------------------------------------------------------------------------
  // Register page read data
  // -------------------------------------------------------------------------
  function automatic logic [7:0] reg_byte(input psc_eng_t s,
                                          input logic [15:0] a);
    logic [7:0] v;
    v = `PSC_FILL;
    if (a == `PSC_ADDR_PIN)
      v = s.pin_snap;
    else if (a == `PSC_ADDR_OUTL)
      v = s.out_latch;
    else if (a == `PSC_ADDR_ACT)
      v = s.act;
    else if (a == `PSC_ADDR_MASK)
      v = s.mask;
    else if (a == `PSC_ADDR_POL)
      v = s.pol;
    else if (a == `PSC_ADDR_CTL)
      v = {s.aux_s2, 3'b000, s.ctl_por, s.ctl_role, s.ctl_comb, s.ctl_src};
    return v;
  endfunction

  // The sample point is a fixed count from the slot start.
  assign cyc_m1 = fast_speed_flag ? OD_M1 : STD_M1;
  assign samp = q_r.in_slot && !q_r.sampled && (q_r.dly == cyc_m1);
  assign rz_reset = !q_r.ctl_role && !q_r.rz_s2;
  assign full = {line_level, q_r.sr[7:1]};
  assign next_addr = q_r.addr + 16'h0001;

  // -------------------------------------------------------------------------
  // Next state
  // -------------------------------------------------------------------------
  always_comb
  begin
    q_nxt = q_r;
    crc_clear = 1'b0;
    crc_shift = 1'b0;
    crc_din = 1'b0;
    src = 8'h00;
    hit = 8'h00;

    q_nxt.pin_s1 = channel_pin_in;
    q_nxt.pin_s2 = q_r.pin_s1;
    q_nxt.pin_prev = q_r.pin_s2;
    q_nxt.rz_s1 = reset_strobe_pin_in;
    q_nxt.rz_s2 = q_r.rz_s1;
    q_nxt.aux_s1 = aux_supply_pin;
    q_nxt.aux_s2 = q_r.aux_s1;

    // A pin change in the same cycle as a clear still sets the latch.
    if (act_clear || rz_reset)
    begin
      q_nxt.act = 8'h00;
    end
    q_nxt.act = q_nxt.act | (q_r.pin_s2 ^ q_r.pin_prev);

    if (cfg_wr)
    begin
      if (cfg_addr == `PSC_ADDR_MASK)
        q_nxt.mask = cfg_data;
      else if (cfg_addr == `PSC_ADDR_POL)
        q_nxt.pol = cfg_data;
      else if (cfg_addr == `PSC_ADDR_CTL)
      begin
        q_nxt.ctl_src = cfg_data[`PSC_CTL_SRC_BIT];
        q_nxt.ctl_comb = cfg_data[`PSC_CTL_COMB_BIT];
        q_nxt.ctl_role = cfg_data[`PSC_CTL_ROLE_BIT];
        q_nxt.ctl_por = q_r.ctl_por & cfg_data[`PSC_CTL_POR_BIT];
      end
    end

    if (slot_begin)
    begin
      q_nxt.in_slot = 1'b1;
      q_nxt.dly = 8'h00;
      q_nxt.sampled = 1'b0;
    end
    else if (q_r.in_slot && !q_r.sampled)
    begin
      q_nxt.dly = q_r.dly + 8'h01;
      q_nxt.sampled = samp;
    end

    // Bit processing at the sample point of each slot.
    if (samp)
    begin
      q_nxt.bitcnt = q_r.bitcnt + 4'h1;
      q_nxt.sr = full;
      q_nxt.txsr = {1'b1, q_r.txsr[15:1]};
      unique case (q_r.st)
        ST_IDLE, ST_ONES, ST_HALT:
        begin
          q_nxt.bitcnt = 4'h0;
        end
        ST_CMD:
        begin
          crc_shift = 1'b1;
          crc_din = line_level;
          if (q_r.bitcnt == 4'h7)
          begin
            q_nxt.bitcnt = 4'h0;
            q_nxt.bytecnt = 5'h00;
            q_nxt.ld = 1'b1;
            if (full == `PSC_CMD_READ_REGS)
              q_nxt.st = ST_ADDR;
            else if (full == `PSC_CMD_STREAM)
            begin
              q_nxt.st = ST_SDATA;
              q_nxt.pin_snap = q_r.pin_s2;
            end
            else if (full == `PSC_CMD_WRITE)
              q_nxt.st = ST_WDATA;
            else
              q_nxt.st = ST_HALT;
          end
        end
        ST_ADDR:
        begin
          crc_shift = 1'b1;
          crc_din = line_level;
          if (q_r.bitcnt == 4'h7)
          begin
            q_nxt.bitcnt = 4'h0;
            if (q_r.bytecnt == 5'h00)
            begin
              q_nxt.addr = {8'h00, full};
              q_nxt.bytecnt = 5'h01;
            end
            else
            begin
              q_nxt.addr = {full, q_r.addr[7:0]};
              if (q_r.addr[7:0] == `PSC_LOW_PIN)
                q_nxt.pin_snap = q_r.pin_s2;
              q_nxt.ld = 1'b1;
              q_nxt.st = ({full, q_r.addr[7:0]} > `PSC_ADDR_LAST) ?
                         ST_RCRC : ST_RDATA;
            end
          end
        end
        ST_RDATA:
        begin
          crc_shift = 1'b1;
          crc_din = q_r.txsr[0];
          if (q_r.bitcnt == 4'h7)
          begin
            if (q_r.addr == `PSC_ADDR_PRESAMPLE)
              q_nxt.pin_snap = q_r.pin_s2;
            q_nxt.bitcnt = 4'h0;
            q_nxt.addr = next_addr;
            q_nxt.ld = 1'b1;
            if (next_addr > `PSC_ADDR_LAST)
              q_nxt.st = ST_RCRC;
          end
        end
        ST_RCRC:
        begin
          if (q_r.bitcnt == 4'hf)
          begin
            q_nxt.bitcnt = 4'h0;
            q_nxt.st = ST_ONES;
            q_nxt.ld = 1'b1;
          end
        end
        ST_SDATA:
        begin
          crc_shift = 1'b1;
          crc_din = q_r.txsr[0];
          if (q_r.bitcnt == 4'h7)
          begin
            q_nxt.bitcnt = 4'h0;
            q_nxt.ld = 1'b1;
            if (q_r.bytecnt == LAST_BYTE)
            begin
              q_nxt.bytecnt = 5'h00;
              q_nxt.st = ST_SCRC;
            end
            else
            begin
              q_nxt.bytecnt = q_r.bytecnt + 5'h01;
              q_nxt.pin_snap = q_r.pin_s2;
            end
          end
        end
        ST_SCRC:
        begin
          if (q_r.bitcnt == 4'hf)
          begin
            q_nxt.bitcnt = 4'h0;
            q_nxt.ld = 1'b1;
            q_nxt.st = ST_SDATA;
            q_nxt.pin_snap = q_r.pin_s2;
          end
        end
        ST_WDATA:
        begin
          if (q_r.bitcnt == 4'h7)
          begin
            q_nxt.bitcnt = 4'h0;
            q_nxt.wr_data = full;
            q_nxt.st = ST_WINV;
          end
        end
        ST_WINV:
        begin
          if (q_r.bitcnt == 4'h7)
          begin
            q_nxt.bitcnt = 4'h0;
            if (full == ~q_r.wr_data)
            begin
              q_nxt.st = ST_WCONF;
              q_nxt.ld = 1'b1;
              if (line_level)
                q_nxt.out_latch = q_r.wr_data;
              else
                q_nxt.apply_pend = 1'b1;
            end
            else
            begin
              q_nxt.st = ST_HALT;
            end
          end
        end
        ST_WCONF:
        begin
          if (q_r.bitcnt == 4'h7)
          begin
            q_nxt.bitcnt = 4'h0;
            q_nxt.ld = 1'b1;
            q_nxt.st = ST_WSTAT;
            q_nxt.pin_snap = q_r.pin_s2;
          end
        end
        ST_WSTAT:
        begin
          if (q_r.bitcnt == 4'h7)
          begin
            q_nxt.bitcnt = 4'h0;
            q_nxt.ld = 1'b1;
            q_nxt.st = ST_WDATA;
          end
        end
        default:
        begin
          q_nxt.st = ST_HALT;
        end
      endcase
    end

    // Byte loads and the slot-end output change happen after the sample.
    if (slot_end)
    begin
      q_nxt.in_slot = 1'b0;
      if (q_r.apply_pend)
      begin
        q_nxt.out_latch = q_r.wr_data;
        q_nxt.apply_pend = 1'b0;
      end
      if (q_r.ld)
      begin
        q_nxt.ld = 1'b0;
        if (q_r.st == ST_RDATA)
          q_nxt.txsr = {`PSC_FILL, reg_byte(q_r, q_r.addr)};
        else if (q_r.st == ST_RCRC || q_r.st == ST_SCRC)
        begin
          q_nxt.txsr = ~crc;
          crc_clear = (q_r.st == ST_SCRC);
        end
        else if (q_r.st == ST_SDATA || q_r.st == ST_WSTAT)
          q_nxt.txsr = {`PSC_FILL, q_r.pin_snap};
        else if (q_r.st == ST_WCONF)
          q_nxt.txsr = {`PSC_FILL, `PSC_CONFIRM};
        else
          q_nxt.txsr = 16'hffff;
      end
      q_nxt.tx_bit = q_nxt.txsr[0];
    end

    if (ctl_start && q_r.st == ST_IDLE)
    begin
      q_nxt.st = ST_CMD;
      q_nxt.bitcnt = 4'h0;
      crc_clear = 1'b1;
    end

    // A bus reset ends any transfer at once.
    if (bus_reset)
    begin
      q_nxt.st = ST_IDLE;
      q_nxt.bitcnt = 4'h0;
      q_nxt.bytecnt = 5'h00;
      q_nxt.in_slot = 1'b0;
      q_nxt.ld = 1'b0;
      q_nxt.apply_pend = 1'b0;
      q_nxt.txsr = 16'hffff;
      q_nxt.tx_bit = 1'b1;
    end

    if (rz_reset)
    begin
      q_nxt.out_latch = 8'hff;
      q_nxt.apply_pend = 1'b0;
    end
    q_nxt.pin_oe = ~q_nxt.out_latch;

    // Strobe covers the two low bits of stream pin bytes and the confirmation.
    q_nxt.strobe_oe = q_nxt.ctl_role && !q_nxt.ld &&
                      (q_nxt.st == ST_SDATA || q_nxt.st == ST_WCONF) &&
                      (q_nxt.bitcnt < 4'h2);

    src = q_r.ctl_src ? q_r.act : q_r.pin_s2;
    hit = ~(src ^ q_r.pol);
    q_nxt.resp = q_r.ctl_por ||
                 (q_r.ctl_comb ? &(hit | ~q_r.mask) : |(hit & q_r.mask));

    if (!ce)
    begin
      q_nxt = q_r;
      crc_clear = 1'b0;
      crc_shift = 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      q_r <= RESET_Q;
    end
    else
    begin
      q_r <= q_nxt;
    end
  end

  psc_crc16 u_crc
  (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .clear(crc_clear),
    .shift(crc_shift),
    .din(crc_din),
    .crc(crc)
  );

  assign channel_pin_out = {8{q_r.lo}};
  assign channel_pin_oe = q_r.pin_oe;
  assign reset_strobe_pin_out = q_r.lo;
  assign reset_strobe_pin_oe = q_r.strobe_oe;
  assign tx_bit = q_r.tx_bit;
  assign search_response = q_r.resp;
endmodule

// ===== verilog/psc_pkg.sv
/*
  Types of the switch command engine: transfer states and the state
  records of the engine and of its checksum unit.
  Assumes psc_defs.svh is on the include path.
*/
package psc_pkg;

  typedef enum logic [12:0]
  {
    ST_IDLE  = 13'h0001,
    ST_CMD   = 13'h0002,
    ST_ADDR  = 13'h0004,
    ST_RDATA = 13'h0008,
    ST_RCRC  = 13'h0010,
    ST_ONES  = 13'h0020,
    ST_SDATA = 13'h0040,
    ST_SCRC  = 13'h0080,
    ST_WDATA = 13'h0100,
    ST_WINV  = 13'h0200,
    ST_WCONF = 13'h0400,
    ST_WSTAT = 13'h0800,
    ST_HALT  = 13'h1000
  } psc_state_t;

  typedef struct packed
  {
    logic [15:0] crc;
  } psc_crc_t;

  typedef struct packed
  {
    psc_state_t st;
    logic [3:0] bitcnt;
    logic [4:0] bytecnt;
    logic [7:0] sr;
    logic [15:0] txsr;
    logic [15:0] addr;
    logic [7:0] wr_data;
    logic [7:0] dly;
    logic in_slot;
    logic sampled;
    logic ld;
    logic apply_pend;
    logic [7:0] pin_s1;
    logic [7:0] pin_s2;
    logic [7:0] pin_prev;
    logic rz_s1;
    logic rz_s2;
    logic aux_s1;
    logic aux_s2;
    logic [7:0] pin_snap;
    logic [7:0] out_latch;
    logic [7:0] act;
    logic [7:0] mask;
    logic [7:0] pol;
    logic ctl_src;
    logic ctl_comb;
    logic ctl_role;
    logic ctl_por;
    logic tx_bit;
    logic [7:0] pin_oe;
    logic strobe_oe;
    logic resp;
    logic lo;
  } psc_eng_t;

endpackage
